// >>> shared/network_quality_pkg.sv
// constants shared by the network quality and remote signal block
// assumes a 16-bit register port and a 64-station network engine
package network_quality_pkg;
	// register port geometry
	localparam int DATA_W    = 16;
	localparam int ADDR_W    = 4;
	localparam int STATION_W = 6;
	localparam int STATIONS  = 64;
	localparam int CNT_W     = 8;

	// register indices on the plain port
	localparam logic [3:0] ADDR_CARE_COUNTERS = 4'h0;
	localparam logic [3:0] ADDR_BASIC_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_QUERY_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_STATION_SETUP = 4'h3;
	localparam logic [3:0] ADDR_MEMBER_FLAGS0 = 4'h4;
	localparam logic [3:0] ADDR_MEMBER_FLAGS3 = 4'h7;

	// care_event_counters fields
	localparam int DEAD_COUNT_LSB   = 0;
	localparam int MEMBER_COUNT_LSB = 8;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_ONE = 8'h01;

	// basic_control fields and reset
	localparam int SHORT_ALERT_PULSE_BIT = 14;
	localparam logic [15:0] BASIC_CONTROL_RESET = 16'h0000;

	// query_control fields
	localparam int TARGET_STATION_LSB = 0;
	localparam int REMOTE_REQ_BIT     = 7;

	// station_setup fields
	localparam int STATION_ADDRESS_LSB = 0;
	localparam int RX_TRIGGER_EN_BIT   = 8;

	// link history thresholds, as counts held before the current event
	localparam logic [1:0] DEAD_RUN_BEFORE_LOSS  = 2'h2;
	localparam logic [1:0] EST_RUN_BEFORE_STABLE = 2'h3;

	// alert timing, in driving clock periods and bit times
	localparam int LONG_ALERT_CLKS  = 2096896;
	localparam int SHORT_ALERT_BITS = 6;
	localparam int BIT_TIME_CLKS    = 10;
	localparam int CH_DEAD          = 0;
	localparam int CH_MEMBER        = 1;
endpackage

// >>> core/network_quality_indicators.sv
// network quality alerts, link-stable indicator and remote signal pin
// assumes a network engine on clk_in that reports one station per pulse
`timescale 1ns/1ps

// How it works
// - dead link pulses its alert low, unmasked
// - dead links counted in low byte, saturating
// - writing bit 0 clears dead-link count
// - dead-link pulse is retriggerable long one-shot
// - short-pulse bit shortens both alert pulses
// - resize link loss counts as dead link
// - three consecutive dead links mean member loss
// - member losses counted in high byte, saturating
// - writing bit 8 clears member-loss count
// - member-loss pulse is retriggerable long one-shot
// - resize link loss counts as member loss
// - fourth consecutive establishment sets member flag
// - indicator low while any other member flag
// - remote command goes out only while running
// - remote signal pin low after reset
// - received remote command toggles the pin
// - received command raises trigger when enabled
// - request bit clears once command is sent
// - unknown target address is still sent
module network_quality_indicators #(
	parameter int LONG_ALERT_CLKS = network_quality_pkg::LONG_ALERT_CLKS,
	parameter int BIT_TIME_CLKS   = network_quality_pkg::BIT_TIME_CLKS
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [15:0] reg_rdata_out,
	input  wire logic [5:0]  station_in,
	input  wire logic        link_ok_in,
	input  wire logic        link_dead_in,
	input  wire logic        link_resized_off_in,
	input  wire logic        run_phase_in,
	input  wire logic        remote_rx_in,
	input  wire logic        remote_sent_in,
	output logic             remote_req_out,
	output logic      [5:0]  remote_target_out,
	output logic             remote_signal_out,
	output logic             remote_rx_trigger_out,
	output logic             dead_link_alert_n_out,
	output logic             member_loss_alert_n_out,
	output logic             link_stable_indicator_n_out
);

	localparam int STATIONS = network_quality_pkg::STATIONS;
	localparam int CNT_W    = network_quality_pkg::CNT_W;
	// short pulse length in clocks, from bit times
	localparam int SHORT_CLKS = network_quality_pkg::SHORT_ALERT_BITS * BIT_TIME_CLKS;
	// timer wide enough for the long one-shot
	localparam int TW = $clog2(LONG_ALERT_CLKS + 1);
	localparam logic [TW-1:0] LONG_LOAD  = TW'(LONG_ALERT_CLKS);
	localparam logic [TW-1:0] SHORT_LOAD = TW'(SHORT_CLKS);
	localparam logic [TW-1:0] TIMER_ONE  = TW'(1);

	// refuse settings the timer cannot serve
	if (BIT_TIME_CLKS < 1 || SHORT_CLKS > LONG_ALERT_CLKS || LONG_ALERT_CLKS < 2) begin : g_bad
		$error("alert timing parameters out of range");
	end

	// one-hot decode of a station address, used for events and self
	function automatic logic [STATIONS-1:0] station_onehot(input logic [5:0] addr);
		logic [STATIONS-1:0] onehot;
		onehot       = '0;
		onehot[addr] = 1'b1;
		return onehot;
	endfunction

	// software visible state
	logic [15:0] basic_control_ff;     // stored whole, bit 14 steers pulses
	logic [5:0]  target_station_ff;    // remote command destination
	logic        remote_pending_ff;    // request bit of query_control
	logic [5:0]  station_address_ff;   // own address, excluded from indicator
	logic        rx_trigger_en_ff;     // gate for the receive trigger
	logic [15:0] rdata_ff;             // read data, valid one cycle after strobe

	// event counters and alert timers, index 0 dead link, 1 member loss
	logic [CNT_W-1:0] count_ff [2];
	logic [TW-1:0]    timer_ff [2];
	logic [1:0]       alert_n_ff;

	// output flops
	logic        remote_req_ff;
	logic        remote_signal_ff;
	logic        rx_trigger_ff;
	logic        stable_n_ff;

	// decoded strobes and events
	logic [STATIONS-1:0] event_hit;    // station named by the engine
	logic [STATIONS-1:0] self_mask;    // own station bit
	logic [STATIONS-1:0] member_vec;   // member flags of all stations
	logic [STATIONS-1:0] loss_vec;     // stations losing membership now
	logic [1:0]          event_now;    // events this cycle per channel
	logic [1:0]          clear_now;    // counter clears this cycle
	logic                wr_care;
	logic                wr_basic;
	logic                wr_query;
	logic                wr_setup;

	assign event_hit = station_onehot(station_in);
	assign self_mask = station_onehot(station_address_ff);

	// register write decode
	assign wr_care  = reg_wr_in && (reg_addr_in == network_quality_pkg::ADDR_CARE_COUNTERS);
	assign wr_basic = reg_wr_in && (reg_addr_in == network_quality_pkg::ADDR_BASIC_CONTROL);
	assign wr_query = reg_wr_in && (reg_addr_in == network_quality_pkg::ADDR_QUERY_CONTROL);
	assign wr_setup = reg_wr_in && (reg_addr_in == network_quality_pkg::ADDR_STATION_SETUP);

	// dead link channel, a resize loss of an established link included
	assign event_now[network_quality_pkg::CH_DEAD] = link_dead_in || link_resized_off_in;
	// member loss channel, any station reaching its loss condition
	assign event_now[network_quality_pkg::CH_MEMBER] = |loss_vec;

	// clears are write-one, other bits of the write are ignored
	assign clear_now[network_quality_pkg::CH_DEAD] =
		wr_care && reg_wdata_in[network_quality_pkg::DEAD_COUNT_LSB];
	assign clear_now[network_quality_pkg::CH_MEMBER] =
		wr_care && reg_wdata_in[network_quality_pkg::MEMBER_COUNT_LSB];

	// per-station link history: consecutive runs and member flag
	for (genvar s = 0; s < STATIONS; s++) begin : g_station
		logic [1:0] est_run_ff;   // consecutive establishments, held at 3
		logic [1:0] dead_run_ff;  // consecutive dead links, held at 3
		logic       member_ff;    // link regarded as stable

		// third consecutive dead link, or a resize loss, drops the member
		assign loss_vec[s] = event_hit[s] && (link_resized_off_in
			|| (link_dead_in
			&& dead_run_ff == network_quality_pkg::DEAD_RUN_BEFORE_LOSS));
		assign member_vec[s] = member_ff;

		// history update; the engine raises at most one event per cycle
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				est_run_ff  <= 2'h0;
				dead_run_ff <= 2'h0;
				member_ff   <= 1'b0;
			end else if (event_hit[s] && link_resized_off_in) begin
				// resizing cut the link: history starts over
				est_run_ff  <= 2'h0;
				dead_run_ff <= 2'h0;
				member_ff   <= 1'b0;
			end else if (event_hit[s] && link_ok_in) begin
				dead_run_ff <= 2'h0;
				// the fourth establishment in a row marks the link stable
				if (est_run_ff == network_quality_pkg::EST_RUN_BEFORE_STABLE) begin
					member_ff <= 1'b1;
				end else begin
					est_run_ff <= est_run_ff + 2'h1;
				end
			end else if (event_hit[s] && link_dead_in) begin
				est_run_ff <= 2'h0;
				// held at 3 so a long outage reports one member loss only
				if (dead_run_ff != 2'h3) begin
					dead_run_ff <= dead_run_ff + 2'h1;
				end
				if (loss_vec[s]) begin
					member_ff <= 1'b0;
				end
			end
		end
	end

	// counters and one-shots, one pair per alert channel
	for (genvar c = 0; c < 2; c++) begin : g_alert
		// saturating count; an event in the clearing cycle is kept
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				count_ff[c] <= '0;
			end else if (event_now[c] && clear_now[c]) begin
				count_ff[c] <= network_quality_pkg::COUNT_ONE;
			end else if (event_now[c]) begin
				// never wraps past 255
				if (count_ff[c] != network_quality_pkg::COUNT_MAX) begin
					count_ff[c] <= count_ff[c] + network_quality_pkg::COUNT_ONE;
				end
			end else if (clear_now[c]) begin
				count_ff[c] <= '0;
			end
		end

		// retriggerable one-shot: every event reloads the full length
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				timer_ff[c] <= '0;
			end else if (event_now[c]) begin
				// short mode is for counting pulses in external logic
				if (basic_control_ff[network_quality_pkg::SHORT_ALERT_PULSE_BIT]) begin
					timer_ff[c] <= SHORT_LOAD;
				end else begin
					timer_ff[c] <= LONG_LOAD;
				end
			end else if (timer_ff[c] != '0) begin
				timer_ff[c] <= timer_ff[c] - TIMER_ONE;
			end
		end

		// pin low for exactly the loaded count, from the cycle after the event
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				alert_n_ff[c] <= 1'b1;
			end else begin
				// masks play no part here
				alert_n_ff[c] <= !(event_now[c] || timer_ff[c] > TIMER_ONE);
			end
		end
	end

	// basic_control: plain storage
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			basic_control_ff <= network_quality_pkg::BASIC_CONTROL_RESET;
		end else if (wr_basic) begin
			basic_control_ff <= reg_wdata_in;
		end
	end

	// station_setup: own address and trigger enable
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			station_address_ff <= 6'h00;
			rx_trigger_en_ff   <= 1'b0;
		end else if (wr_setup) begin
			station_address_ff <= reg_wdata_in[network_quality_pkg::STATION_ADDRESS_LSB +: 6];
			rx_trigger_en_ff   <= reg_wdata_in[network_quality_pkg::RX_TRIGGER_EN_BIT];
		end
	end

	// query_control: target and request; software write beats the sent clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			target_station_ff <= 6'h00;
			remote_pending_ff <= 1'b0;
		end else if (wr_query) begin
			// any address is accepted, present on the network or not
			target_station_ff <= reg_wdata_in[network_quality_pkg::TARGET_STATION_LSB +: 6];
			remote_pending_ff <= reg_wdata_in[network_quality_pkg::REMOTE_REQ_BIT];
		end else if (remote_sent_in) begin
			remote_pending_ff <= 1'b0;
		end
	end

	// request toward the engine only in the running phase
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			remote_req_ff <= 1'b0;
		end else begin
			// drops with the sent pulse so no second command is taken
			remote_req_ff <= remote_pending_ff && run_phase_in && !remote_sent_in;
		end
	end

	// remote signal pin toggles per received command
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			remote_signal_ff <= 1'b0;
		end else if (remote_rx_in) begin
			remote_signal_ff <= !remote_signal_ff;
		end
	end

	// one-cycle trigger toward the host on reception
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_trigger_ff <= 1'b0;
		end else begin
			rx_trigger_ff <= remote_rx_in && rx_trigger_en_ff;
		end
	end

	// indicator low while another station is a member
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stable_n_ff <= 1'b1;
		end else begin
			// own bit masked: a station cannot vouch for itself
			stable_n_ff <= !(|(member_vec & ~self_mask));
		end
	end

	// read data: registered, zero outside the cycle after a read
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_ff <= 16'h0000;
		end else if (!reg_rd_in) begin
			rdata_ff <= 16'h0000;
		end else begin
			case (reg_addr_in)
				network_quality_pkg::ADDR_CARE_COUNTERS: begin
					rdata_ff <= {count_ff[network_quality_pkg::CH_MEMBER],
						count_ff[network_quality_pkg::CH_DEAD]};
				end
				network_quality_pkg::ADDR_BASIC_CONTROL: begin
					rdata_ff <= basic_control_ff;
				end
				network_quality_pkg::ADDR_QUERY_CONTROL: begin
					// query bit 6 and type bits are not built, read zero
					rdata_ff <= {8'h00, remote_pending_ff, 1'b0, target_station_ff};
				end
				network_quality_pkg::ADDR_STATION_SETUP: begin
					rdata_ff <= {7'h00, rx_trigger_en_ff, 2'h0, station_address_ff};
				end
				network_quality_pkg::ADDR_MEMBER_FLAGS0,
				network_quality_pkg::ADDR_MEMBER_FLAGS0 + 4'h1,
				network_quality_pkg::ADDR_MEMBER_FLAGS0 + 4'h2,
				network_quality_pkg::ADDR_MEMBER_FLAGS3: begin
					// four words of member flags, station 0 in bit 0 of word 0
					rdata_ff <= member_vec[16 * reg_addr_in[1:0] +: 16];
				end
				default: begin
					// unmapped index reads zero
					rdata_ff <= 16'h0000;
				end
			endcase
		end
	end

	// every output straight from a flop
	assign reg_rdata_out               = rdata_ff;
	assign remote_req_out              = remote_req_ff;
	assign remote_target_out           = target_station_ff;
	assign remote_signal_out           = remote_signal_ff;
	assign remote_rx_trigger_out       = rx_trigger_ff;
	assign dead_link_alert_n_out       = alert_n_ff[network_quality_pkg::CH_DEAD];
	assign member_loss_alert_n_out     = alert_n_ff[network_quality_pkg::CH_MEMBER];
	assign link_stable_indicator_n_out = stable_n_ff;

endmodule

// >>> tb/nq_engine_model.sv
// network engine stand-in that puts wanted remote commands on the wire
// assumes the block's request level and the single block clock
`timescale 1ns/1ps
module nq_engine_model (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       req_in,   // command wanted by the block
	input  wire logic [3:0] delay_in, // slot wait, 0 answers at once
	output logic            sent_out  // one-cycle sent pulse
);
	logic [3:0] wait_ff; // cycles the request has waited
	// sends only while the request stands, so a dropped request is never answered
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_ff  <= 4'h0;
			sent_out <= 1'b0;
		end else begin
			sent_out <= req_in && !sent_out && wait_ff == delay_in;
			wait_ff  <= (req_in && !sent_out && wait_ff != delay_in) ? wait_ff + 4'h1 : 4'h0;
		end
	end
endmodule

// >>> tb/network_quality_indicators_sva.sv
// port checks for the network quality block
// assumes bind onto the block, one clock, reset async low
`timescale 1ns/1ps
module nq_checker #(
	parameter int LONG_ALERT_CLKS = 40,
	parameter int BIT_TIME_CLKS   = 2
) (
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [3:0]  reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic [5:0]  station_in,
	input wire logic        link_ok_in,
	input wire logic        link_dead_in,
	input wire logic        link_resized_off_in,
	input wire logic        run_phase_in,
	input wire logic        remote_rx_in,
	input wire logic        remote_sent_in,
	input wire logic        remote_req_out,
	input wire logic [5:0]  remote_target_out,
	input wire logic        remote_signal_out,
	input wire logic        remote_rx_trigger_out,
	input wire logic        dead_link_alert_n_out,
	input wire logic        member_loss_alert_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic       short_ff;    // mirror of the short pulse bit
	logic       rx_en_ff;    // mirror of the receive trigger enable
	logic [1:0] run_ff [64]; // dead-link run per station
	int         dage_ff;     // cycles since last dead link, 0 idle
	int         mage_ff;     // cycles since last member loss, 0 idle
	wire dead_ev = link_dead_in | link_resized_off_in;
	wire mem_ev  = link_resized_off_in | (link_dead_in && run_ff[station_in] == 2'h2);
	wire rx_en   = remote_rx_in && rx_en_ff;
	wire q_wr    = reg_wr_in && reg_addr_in == network_quality_pkg::ADDR_QUERY_CONTROL;
	int  limit; // pulse length; mode is only changed while both pulses are idle
	assign limit = short_ff ? network_quality_pkg::SHORT_ALERT_BITS * BIT_TIME_CLKS
		: LONG_ALERT_CLKS;
	// register mirrors and dead-link runs
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			short_ff <= 1'b0;
			rx_en_ff <= 1'b0;
			for (int i = 0; i < 64; i++)
				run_ff[i] <= 2'h0;
		end else begin
			if (reg_wr_in && reg_addr_in == network_quality_pkg::ADDR_BASIC_CONTROL)
				short_ff <= reg_wdata_in[14];
			if (reg_wr_in && reg_addr_in == network_quality_pkg::ADDR_STATION_SETUP)
				rx_en_ff <= reg_wdata_in[8];
			// a resize loss starts the history over, as a link up does
			if (link_ok_in || link_resized_off_in)
				run_ff[station_in] <= 2'h0;
			else if (link_dead_in && run_ff[station_in] != 2'h3)
				run_ff[station_in] <= run_ff[station_in] + 2'h1;
		end
	end
	// pulse ages, reloaded by each new cause
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dage_ff <= 0;
			mage_ff <= 0;
		end else begin
			dage_ff <= dead_ev ? 1 : (dage_ff != 0 && dage_ff < limit) ? dage_ff + 1 : 0;
			mage_ff <= mem_ev ? 1 : (mage_ff != 0 && mage_ff < limit) ? mage_ff + 1 : 0;
		end
	end
	AST_DEAD_PULSE: assert property (dead_link_alert_n_out == (dage_ff == 0))
		else $error("dead-link alert pulse wrong");
	AST_MEMBER_PULSE: assert property (member_loss_alert_n_out == (mage_ff == 0))
		else $error("member-loss alert pulse wrong");
	AST_REQ_IDLE: assert property (!run_phase_in |=> !remote_req_out)
		else $error("request outside running phase");
	AST_REQ_ISSUE: assert property ((q_wr && reg_wdata_in[7] && run_phase_in) ##1
		(run_phase_in && !remote_sent_in) |=> remote_req_out &&
		remote_target_out == 6'($past(reg_wdata_in, 2))) else $error("request not issued");
	AST_REQ_HOLD: assert property (remote_req_out && !remote_sent_in && run_phase_in
		|=> remote_req_out) else $error("request dropped early");
	AST_REQ_DONE: assert property (remote_req_out && remote_sent_in && !reg_wr_in
		|=> !remote_req_out) else $error("request kept after send");
	AST_RX_TOGGLE: assert property (remote_rx_in |=> remote_signal_out != $past(remote_signal_out))
		else $error("remote pin did not toggle");
	AST_RX_QUIET: assert property (!remote_rx_in |=> $stable(remote_signal_out))
		else $error("remote pin moved");
	AST_RX_TRIGGER: assert property (1'b1 |=> remote_rx_trigger_out == $past(rx_en))
		else $error("receive trigger wrong");
	cover property (mem_ev && short_ff);
	cover property (remote_req_out && remote_sent_in);
	cover property (rx_en);
	cover property (dead_ev && dage_ff != 0);
endmodule
bind network_quality_indicators nq_checker #(.LONG_ALERT_CLKS(LONG_ALERT_CLKS),
	.BIT_TIME_CLKS(BIT_TIME_CLKS)) u_chk (.*);

// >>> tb/network_quality_indicators_test.sv
// self-checking bench for the network quality block
// assumes the engine model answers requests and the checker is bound
`timescale 1ns/1ps
module network_quality_indicators_test;
	logic        clk_in, rst_n_in, reg_wr_in, reg_rd_in, link_ok_in, link_dead_in;
	logic        link_resized_off_in, run_phase_in, remote_rx_in, remote_sent_in;
	logic        remote_req_out, remote_signal_out, remote_rx_trigger_out;
	logic        dead_link_alert_n_out, member_loss_alert_n_out, link_stable_indicator_n_out;
	logic [3:0]  reg_addr_in, eng_delay;
	logic [15:0] reg_wdata_in, reg_rdata_out;
	logic [5:0]  station_in, remote_target_out;
	logic [63:0] flag;              // expected member flags
	logic [1:0]  est [64], run [64]; // expected link and dead runs
	logic [7:0]  dcnt, mcnt;        // expected counters
	logic        sig;               // expected remote pin
	int          errors, checked;
	localparam int LONG_CLKS = 40; // short counts keep the run brief
	localparam int BIT_CLKS  = 2;
	network_quality_indicators #(.LONG_ALERT_CLKS(LONG_CLKS), .BIT_TIME_CLKS(BIT_CLKS)) uut (.*);
	nq_engine_model eng (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(remote_req_out),
		.delay_in(eng_delay), .sent_out(remote_sent_in));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// cuts a hang short
	initial begin
		#2000000 errors++;
		finish_test();
	end
	task automatic finish_test();
		if (errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
	endtask
	function automatic logic [7:0] inc(input logic [7:0] c);
		return c == 8'hFF ? c : c + 8'h01;
	endfunction
	function automatic logic ind_exp();
		for (int i = 0; i < 64; i++)
			if (flag[i] && i != 2) return 1'b0;
		return 1'b1;
	endfunction
	task automatic reset_model();
		flag = '0;
		dcnt = 8'h00;
		mcnt = 8'h00;
		sig = 1'b0;
		for (int i = 0; i < 64; i++) begin
			est[i] = 2'h0;
			run[i] = 2'h0;
		end
	endtask
	// one event pulse: 0 link up, 1 dead link, 2 resize loss
	task automatic ev(input int k, input logic [5:0] st);
		@(posedge clk_in);
		station_in <= st;
		link_ok_in <= k == 0;
		link_dead_in <= k == 1;
		link_resized_off_in <= k == 2;
		@(posedge clk_in);
		{link_ok_in, link_dead_in, link_resized_off_in} <= 3'h0;
		if (k == 0) begin
			if (est[st] == 2'h3) flag[st] = 1'b1;
			else est[st]++;
			run[st] = 2'h0;
		end else begin
			dcnt = inc(dcnt);
			if (k == 2 || run[st] == 2'h2) begin
				mcnt = inc(mcnt);
				flag[st] = 1'b0;
			end
			if (k == 2) run[st] = 2'h0;
			else if (run[st] != 2'h3) run[st]++;
			est[st] = 2'h0;
		end
	endtask
	// event on an idle member channel: dead pin low for exactly len cycles
	task automatic alert_chk(input int k, input logic [5:0] st, input int len);
		ev(k, st);
		#1 chk(dead_link_alert_n_out, 1'b0);
		chk(member_loss_alert_n_out, k != 2);
		repeat (len - 1) @(posedge clk_in);
		#1 chk(dead_link_alert_n_out, 1'b0);
		@(posedge clk_in);
		#1 chk(dead_link_alert_n_out, 1'b1);
		chk(member_loss_alert_n_out, 1'b1);
	endtask
	task automatic ind_chk();
		@(posedge clk_in);
		#1 chk(link_stable_indicator_n_out, ind_exp());
	endtask
	task automatic wait_req(input logic v);
		int n;
		n = 0;
		while (remote_req_out !== v && n < 40) begin
			@(posedge clk_in);
			#1 n++;
		end
		chk(remote_req_out, v);
	endtask
	initial begin
		void'($urandom(86));
		{rst_n_in, reg_wr_in, reg_rd_in, link_ok_in, link_dead_in, link_resized_off_in} = 6'h0;
		{run_phase_in, remote_rx_in, reg_addr_in, eng_delay} = 10'h000;
		reg_wdata_in = 16'h0000;
		station_in = 6'h00;
		errors = 0;
		checked = 0;
		reset_model();
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1 chk(remote_signal_out, 1'b0);
		rdchk(4'h0, 16'h0000);
		rdchk(4'h1, network_quality_pkg::BASIC_CONTROL_RESET);
		rdchk(4'h9, 16'h0000);
		wr(network_quality_pkg::ADDR_STATION_SETUP, 16'h0102); // own station 2, trigger on
		for (int i = 0; i < 200; i++) begin
			ev($urandom_range(0, 2) == 0, 6'($urandom_range(1, 4)));
			ind_chk();
		end
		rdchk(4'h0, {mcnt, dcnt});
		wr(network_quality_pkg::ADDR_MEMBER_FLAGS0, 16'hFFFF); // read-only, ignored
		rdchk(network_quality_pkg::ADDR_MEMBER_FLAGS0, flag[15:0]);
		repeat (260) ev(1, 6'h05);
		rdchk(4'h0, {mcnt, dcnt});
		wr(4'h0, 16'h0001);
		dcnt = 8'h00;
		rdchk(4'h0, {mcnt, dcnt});
		wr(4'h0, 16'h0100);
		mcnt = 8'h00;
		rdchk(4'h0, {mcnt, dcnt});
		repeat (45) @(posedge clk_in);
		alert_chk(1, 6'h08, LONG_CLKS);
		wr(network_quality_pkg::ADDR_BASIC_CONTROL, 16'h4000);
		rdchk(network_quality_pkg::ADDR_BASIC_CONTROL, 16'h4000);
		repeat (4) ev(0, 6'h07);
		ev(1, 6'h06);
		ev(1, 6'h06);
		ind_chk();
		alert_chk(2, 6'h07, network_quality_pkg::SHORT_ALERT_BITS * BIT_CLKS);
		ind_chk();
		rdchk(4'h0, {mcnt, dcnt});
		repeat (20) @(posedge clk_in);
		wr(network_quality_pkg::ADDR_BASIC_CONTROL, 16'h0000);
		wr(network_quality_pkg::ADDR_QUERY_CONTROL, 16'h0083); // held while not running
		repeat (4) @(posedge clk_in);
		#1 chk(remote_req_out, 1'b0);
		rdchk(network_quality_pkg::ADDR_QUERY_CONTROL, 16'h0083);
		run_phase_in <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			eng_delay <= 4'($urandom_range(0, 7));
			if (t == 1) wr(network_quality_pkg::ADDR_QUERY_CONTROL, 16'h00BF); // no such station
			wait_req(1'b1);
			chk(remote_target_out, t ? 6'h3F : 6'h03);
			wait_req(1'b0);
			rdchk(network_quality_pkg::ADDR_QUERY_CONTROL, t ? 16'h003F : 16'h0003);
		end
		for (int i = 0; i < 3; i++) begin
			if (i == 2) wr(network_quality_pkg::ADDR_STATION_SETUP, 16'h0002); // trigger off
			@(posedge clk_in);
			remote_rx_in <= 1'b1;
			@(posedge clk_in);
			remote_rx_in <= 1'b0;
			sig = ~sig;
			#1 chk(remote_signal_out, sig);
			chk(remote_rx_trigger_out, i != 2);
		end
		rst_n_in <= 1'b0; // second reset with the pin high
		@(posedge clk_in);
		#1 chk(remote_signal_out, 1'b0);
		rst_n_in <= 1'b1;
		reset_model();
		rdchk(4'h0, 16'h0000);
		finish_test();
	end
endmodule
